// ---- pkg/shc_pkg.sv ----
package shc_pkg;

    // register port
    localparam int SHC_ADDR_W = 4;
    localparam int SHC_DATA_W = 8;
    localparam logic [SHC_ADDR_W-1:0] SHC_REG_SETTLE = 4'h0;
    localparam logic [SHC_ADDR_W-1:0] SHC_REG_STATUS = 4'h1;

    // settle_select codes and reset value
    localparam int SHC_SEL_W = 3;
    localparam logic [SHC_SEL_W-1:0] SHC_SEL_SHORT = 3'h0;
    localparam logic [SHC_SEL_W-1:0] SHC_SEL_MID = 3'h2;
    localparam logic [SHC_SEL_W-1:0] SHC_SEL_LONG = 3'h4;
    localparam logic [SHC_SEL_W-1:0] SHC_SETTLE_RST = 3'h4;

    // status field positions
    localparam int SHC_ST_STATE_LSB = 0;
    localparam int SHC_ST_VEC_BIT = 3;
    localparam int SHC_ST_NMI_BIT = 4;

    // settle times in oscillator periods (2^n / oscillator_frequency)
    localparam longint SHC_CLK_HZ = 40_000_000;
    localparam longint SHC_FX_HZ = 40_000_000;
    localparam longint SHC_SETTLE_SHORT_FX = 64'd4096;
    localparam longint SHC_SETTLE_MID_FX = 64'd32768;
    localparam longint SHC_SETTLE_LONG_FX = 64'd131072;
    // least times: round up to whole system clocks
    localparam longint SHC_SETTLE_SHORT_CYC =
        (SHC_SETTLE_SHORT_FX * SHC_CLK_HZ + SHC_FX_HZ - 1) / SHC_FX_HZ;
    localparam longint SHC_SETTLE_MID_CYC =
        (SHC_SETTLE_MID_FX * SHC_CLK_HZ + SHC_FX_HZ - 1) / SHC_FX_HZ;
    localparam longint SHC_SETTLE_LONG_CYC =
        (SHC_SETTLE_LONG_FX * SHC_CLK_HZ + SHC_FX_HZ - 1) / SHC_FX_HZ;

    // wake waits in cpu clocks (cpu clock equals the system clock here)
    localparam int SHC_WAKE_VEC_CLK = 9;
    localparam int SHC_WAKE_NEXT_CLK = 1;

    localparam int SHC_CNT_W = 18;
    localparam int SHC_IRQ_N = 8;

    typedef enum logic [2:0] {
        SHC_RUN = 3'b000,
        SHC_HALT = 3'b001,
        SHC_STOP_SETTLE = 3'b010,
        SHC_STOP = 3'b011,
        SHC_WAKE_SETTLE = 3'b100,
        SHC_WAKE = 3'b101,
        SHC_RST_SETTLE = 3'b110
    } shc_state_e;

    typedef struct packed {
        logic inv_timer;
        logic first_event_counter;
        logic second_event_counter;
        logic third_event_counter;
        logic watch_timer;
        logic watchdog;
        logic adc;
        logic serial;
        logic ext_irq;
    } shc_periph_en_s;

    localparam shc_periph_en_s SHC_PERIPH_OFF = '0;

endpackage : shc_pkg

// ---- rtl/shc_cycle_counter.sv ----
`timescale 1ns/1ps
module shc_cycle_counter #(
    parameter int W = 18,
    parameter logic [W-1:0] RST_VAL = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // control
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    // status
    output logic done_o,
    output logic [W-1:0] count_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    if (W < 2) begin : g_bad_width
        $error("counter width too small");
    end

    // holds at zero once expired, so a stale count never fires again
    assign cnt_d = load_i ? load_val_i : (cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
    // done ignores load: callers reload on done, and gating it would close a loop
    assign done_o = (cnt_q == W'(1));
    assign count_o = cnt_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= RST_VAL;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : shc_cycle_counter

// ---- rtl/shc_release_eval.sv ----
`timescale 1ns/1ps
module shc_release_eval #(
    parameter int N = 8
) (
    // interrupt flags
    input wire logic [N-1:0] req_flags_i,
    input wire logic [N-1:0] mask_bit_i,
    input wire logic global_interrupt_enable_flag_i,
    // result
    output logic pending_o,
    output logic vectored_o
);
    if (N < 1) begin : g_bad_count
        $error("need at least one source");
    end

    assign pending_o = |(req_flags_i & ~mask_bit_i);
    assign vectored_o = pending_o && global_interrupt_enable_flag_i;

endmodule : shc_release_eval

// ---- rtl/shc_standby_ctrl.sv ----
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - halt instruction gates cpu clock, oscillator keeps running
// - halted: timers, serial, watchdog, external irq run; a/d converter stops
// - port output latches held for whole halt
// - unmasked request ends halt; enable picks vectoring or next instruction
// - halt release waits 9-10 clocks vectored, 1-2 clocks otherwise
// - non-maskable request ends halt and always vectors
// - reset during halt ends it and restarts like ordinary reset
// - already pending unmasked source makes standby leave at once
// - stop instruction disables oscillator, halting cpu and clocked system
// - stop passes through halt, waits selected settle time, then stops
// - stopped: only counters one and two on external input, external irq active
// - port output latches held for whole stop
// - stop ends only on unmasked maskable request or reset
// - stop release waits settle time, then vectors or resumes
// - reset release from stop processes reset after settle time
// - settle_select 3 bits picks 2^12, 2^15, 2^17 periods; reset 04H
// - eligible when flag 1 and mask 0; vectoring also needs enable
module shc_standby_ctrl
    import shc_pkg::*;
#(
    parameter int IRQ_N = SHC_IRQ_N,
    parameter int unsigned SETTLE_MID_CYC = 32'(SHC_SETTLE_MID_CYC),
    parameter int unsigned SETTLE_LONG_CYC = 32'(SHC_SETTLE_LONG_CYC)
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // cpu instruction strobes
    input wire logic HALT_EXEC_I,
    input wire logic STOP_EXEC_I,
    // interrupt logic
    input wire logic [IRQ_N-1:0] REQ_FLAGS_I,
    input wire logic [IRQ_N-1:0] MASK_BIT_I,
    input wire logic GLOBAL_INTERRUPT_ENABLE_FLAG_I,
    input wire logic NMI_REQ_I,
    // counter clock selection
    input wire logic FIRST_COUNTER_EXT_INPUT_SEL_I,
    input wire logic SECOND_COUNTER_EXT_INPUT_SEL_I,
    // register port
    input wire logic [SHC_ADDR_W-1:0] REG_ADDR_I,
    input wire logic [SHC_DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WE_I,
    input wire logic REG_RE_I,
    output logic [SHC_DATA_W-1:0] REG_RDATA_O,
    // clock and power control
    output logic CPU_CLK_EN_O,
    output logic OSC_EN_O,
    output shc_periph_en_s PERIPH_EN_O,
    output logic PORT_HOLD_O,
    output logic CPU_RST_HOLD_O,
    // wake signalling to cpu
    output logic WAKE_VECTOR_O,
    output logic WAKE_NMI_O,
    output logic WAKE_NEXT_O
);
    localparam logic [SHC_CNT_W-1:0] CNT_SHORT = SHC_CNT_W'(SHC_SETTLE_SHORT_CYC);
    localparam logic [SHC_CNT_W-1:0] CNT_MID = SHC_CNT_W'(SETTLE_MID_CYC);
    localparam logic [SHC_CNT_W-1:0] CNT_LONG = SHC_CNT_W'(SETTLE_LONG_CYC);
    localparam logic [SHC_CNT_W-1:0] CNT_VEC = SHC_CNT_W'(SHC_WAKE_VEC_CLK);
    localparam logic [SHC_CNT_W-1:0] CNT_NEXT = SHC_CNT_W'(SHC_WAKE_NEXT_CLK);

    if (SETTLE_MID_CYC < 2 || SETTLE_LONG_CYC < 2 || IRQ_N < 1 ||
        SETTLE_MID_CYC >= (1 << SHC_CNT_W) ||
        SETTLE_LONG_CYC >= (1 << SHC_CNT_W)) begin : g_bad_cfg
        $error("settle counts or source count out of range");
    end

    shc_state_e state_q, state_d;
    logic [SHC_SEL_W-1:0] sel_q;
    logic vec_q, vec_d, nmi_q, nmi_d, sel_legal, wr_settle;
    logic cnt_load, cnt_done, pending, pend_vec, halt_release, wake_end;
    logic [SHC_CNT_W-1:0] cnt_load_val, settle_cyc;
    logic [SHC_DATA_W-1:0] rd_mux, rdata_q;
    logic cpu_clk_q, osc_q, hold_q, rst_hold_q, cpu_clk_d, osc_d, hold_d;
    shc_periph_en_s periph_q, periph_d;

    shc_release_eval #(
        .N(IRQ_N)
    ) u_eval (
        .req_flags_i(REQ_FLAGS_I),
        .mask_bit_i(MASK_BIT_I),
        .global_interrupt_enable_flag_i(GLOBAL_INTERRUPT_ENABLE_FLAG_I),
        .pending_o(pending),
        .vectored_o(pend_vec)
    );

    // reset starts the counter at the 2^15 settle time (CNT_MID)
    shc_cycle_counter #(
        .W(SHC_CNT_W),
        .RST_VAL(CNT_MID)
    ) u_cnt (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .load_i(cnt_load),
        .load_val_i(cnt_load_val),
        .done_o(cnt_done),
        .count_o()
    );

    assign settle_cyc = (sel_q == SHC_SEL_SHORT) ? CNT_SHORT :
                        (sel_q == SHC_SEL_MID) ? CNT_MID : CNT_LONG;
    assign sel_legal = (REG_WDATA_I[SHC_SEL_W-1:0] == SHC_SEL_SHORT) ||
                       (REG_WDATA_I[SHC_SEL_W-1:0] == SHC_SEL_MID) ||
                       (REG_WDATA_I[SHC_SEL_W-1:0] == SHC_SEL_LONG);
    // prohibited codes are dropped so the counter never sees an undefined wait
    assign wr_settle = REG_WE_I && (REG_ADDR_I == SHC_REG_SETTLE) && sel_legal;
    assign rd_mux = (REG_ADDR_I == SHC_REG_SETTLE) ? SHC_DATA_W'(sel_q) :
                    (REG_ADDR_I == SHC_REG_STATUS) ? SHC_DATA_W'({nmi_q, vec_q, state_q}) : '0;

    assign halt_release = pending || NMI_REQ_I;
    assign wake_end = (state_q == SHC_WAKE) && cnt_done;

    always_comb begin
        state_d = state_q;
        vec_d = vec_q;
        nmi_d = nmi_q;
        cnt_load = 1'b0;
        cnt_load_val = CNT_NEXT;
        case (state_q)
            SHC_RUN: begin
                if (STOP_EXEC_I) begin
                    if (pending) begin
                        state_d = SHC_WAKE;
                        vec_d = pend_vec;
                        nmi_d = 1'b0;
                        cnt_load = 1'b1;
                        cnt_load_val = pend_vec ? CNT_VEC : CNT_NEXT;
                    end else begin
                        state_d = SHC_STOP_SETTLE;
                        cnt_load = 1'b1;
                        cnt_load_val = settle_cyc;
                    end
                end else if (HALT_EXEC_I) begin
                    if (halt_release) begin
                        state_d = SHC_WAKE;
                        vec_d = pend_vec || NMI_REQ_I;
                        nmi_d = NMI_REQ_I && !pending;
                        cnt_load = 1'b1;
                        cnt_load_val = (pend_vec || NMI_REQ_I) ? CNT_VEC : CNT_NEXT;
                    end else begin
                        state_d = SHC_HALT;
                    end
                end
            end
            SHC_HALT: begin
                if (halt_release) begin
                    state_d = SHC_WAKE;
                    vec_d = pend_vec || NMI_REQ_I;
                    nmi_d = NMI_REQ_I && !pending;
                    cnt_load = 1'b1;
                    cnt_load_val = (pend_vec || NMI_REQ_I) ? CNT_VEC : CNT_NEXT;
                end
            end
            SHC_STOP_SETTLE: begin
                // oscillator still runs, so no second settle
                if (pending) begin
                    state_d = SHC_WAKE;
                    vec_d = pend_vec;
                    nmi_d = 1'b0;
                    cnt_load = 1'b1;
                    cnt_load_val = pend_vec ? CNT_VEC : CNT_NEXT;
                end else if (cnt_done) begin
                    state_d = SHC_STOP;
                end
            end
            SHC_STOP: begin
                if (pending) begin
                    state_d = SHC_WAKE_SETTLE;
                    vec_d = pend_vec;
                    nmi_d = 1'b0;
                    cnt_load = 1'b1;
                    cnt_load_val = settle_cyc;
                end
            end
            SHC_WAKE_SETTLE: begin
                if (cnt_done) begin
                    state_d = SHC_WAKE;
                    cnt_load = 1'b1;
                    cnt_load_val = vec_q ? CNT_VEC : CNT_NEXT;
                end
            end
            SHC_WAKE, SHC_RST_SETTLE: begin
                if (cnt_done) begin
                    state_d = SHC_RUN;
                end
            end
            default: begin
                state_d = SHC_RST_SETTLE;
            end
        endcase
    end

    always_comb begin
        periph_d = SHC_PERIPH_OFF;
        cpu_clk_d = 1'b0;
        osc_d = 1'b1;
        hold_d = 1'b0;
        case (state_d)
            SHC_RUN, SHC_WAKE: begin
                periph_d = '1;
                cpu_clk_d = 1'b1;
            end
            SHC_HALT, SHC_STOP_SETTLE: begin
                periph_d = '1;
                periph_d.adc = 1'b0;
                hold_d = 1'b1;
            end
            SHC_STOP, SHC_WAKE_SETTLE: begin
                osc_d = (state_d == SHC_WAKE_SETTLE);
                periph_d.first_event_counter = FIRST_COUNTER_EXT_INPUT_SEL_I;
                periph_d.second_event_counter = SECOND_COUNTER_EXT_INPUT_SEL_I;
                periph_d.ext_irq = 1'b1;
                hold_d = 1'b1;
            end
            default: begin
                periph_d = SHC_PERIPH_OFF;
            end
        endcase
    end

    // reset forces reset settle from any state
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_q <= SHC_RST_SETTLE;
            vec_q <= 1'b0;
            nmi_q <= 1'b0;
        end else begin
            state_q <= state_d;
            vec_q <= vec_d;
            nmi_q <= nmi_d;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sel_q <= SHC_SETTLE_RST;
        end else if (wr_settle) begin
            sel_q <= REG_WDATA_I[SHC_SEL_W-1:0];
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= REG_RE_I ? rd_mux : '0;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            periph_q <= SHC_PERIPH_OFF;
            cpu_clk_q <= 1'b0;
            osc_q <= 1'b1;
            hold_q <= 1'b0;
            rst_hold_q <= 1'b1;
        end else begin
            periph_q <= periph_d;
            cpu_clk_q <= cpu_clk_d;
            osc_q <= osc_d;
            hold_q <= hold_d;
            rst_hold_q <= (state_d == SHC_RST_SETTLE);
        end
    end

    assign REG_RDATA_O = rdata_q;
    assign CPU_CLK_EN_O = cpu_clk_q;
    assign OSC_EN_O = osc_q;
    assign PERIPH_EN_O = periph_q;
    assign PORT_HOLD_O = hold_q;
    assign CPU_RST_HOLD_O = rst_hold_q;
    assign WAKE_VECTOR_O = wake_end && vec_q;
    assign WAKE_NMI_O = wake_end && vec_q && nmi_q;
    assign WAKE_NEXT_O = wake_end && !vec_q;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    sequence s_halted_quiet;
        state_q == SHC_HALT && !pending && !NMI_REQ_I;
    endsequence

    chk_halt_gates_cpu: assert property (
        state_q == SHC_HALT |-> !CPU_CLK_EN_O && OSC_EN_O)
        else $error("halt must gate cpu and keep oscillator");
    chk_halt_adc_off: assert property (
        state_q == SHC_HALT |-> !PERIPH_EN_O.adc && PERIPH_EN_O.watchdog && PERIPH_EN_O.serial)
        else $error("halt peripheral enables wrong");
    chk_hold_standby: assert property (
        (state_q == SHC_HALT || state_q == SHC_STOP) |-> PORT_HOLD_O)
        else $error("port latches not held in standby");
    chk_masked_stays: assert property (
        s_halted_quiet |=> state_q == SHC_HALT)
        else $error("halt left without release source");
    chk_wake_vec_time: assert property (
        state_q == SHC_HALT && pend_vec |-> ##9 WAKE_VECTOR_O)
        else $error("vectored wake not after 9 clocks");
    chk_wake_next_time: assert property (
        state_q == SHC_HALT && pending && !pend_vec && !NMI_REQ_I |-> ##1 WAKE_NEXT_O)
        else $error("next instruction wake not after 1 clock");
    chk_nmi_vectors: assert property (
        state_q == SHC_HALT && NMI_REQ_I && !pending |-> ##9 (WAKE_VECTOR_O && WAKE_NMI_O))
        else $error("nmi did not vector from halt");
    chk_stop_osc_off: assert property (
        state_q == SHC_STOP |-> !OSC_EN_O && !CPU_CLK_EN_O && !PERIPH_EN_O.watch_timer)
        else $error("stop left oscillator or timers running");
    chk_stop_nmi_ignored: assert property (
        state_q == SHC_STOP && NMI_REQ_I && !pending |=> state_q == SHC_STOP)
        else $error("nmi released stop");
    chk_stop_entry: assert property (
        state_q == SHC_RUN && STOP_EXEC_I && !pending |=>
            state_q == SHC_STOP_SETTLE ##1 OSC_EN_O && !CPU_CLK_EN_O)
        else $error("stop did not pass through settle");
    chk_bad_sel_dropped: assert property (
        REG_WE_I && REG_ADDR_I == SHC_REG_SETTLE && !sel_legal |=> $stable(sel_q))
        else $error("prohibited settle code accepted");

endmodule : shc_standby_ctrl

// ---- testbench/shc_cpu_model.sv ----
`timescale 1ns/1ps
module shc_cpu_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // bench commands
    input wire logic do_halt_i,
    input wire logic do_stop_i,
    // core status from the controller
    input wire logic cpu_clk_en_i,
    input wire logic cpu_rst_hold_i,
    // instruction strobes
    output logic halt_exec_o,
    output logic stop_exec_o
);
    // a gated or held core executes nothing, so no strobe can leave it
    wire logic can_exec = cpu_clk_en_i & ~cpu_rst_hold_i;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            halt_exec_o <= 1'b0;
            stop_exec_o <= 1'b0;
        end else begin
            halt_exec_o <= do_halt_i & can_exec;
            stop_exec_o <= do_stop_i & can_exec;
        end
    end
endmodule : shc_cpu_model

// ---- testbench/standby_halt_stop_control_tb_top.sv ----
`timescale 1ns/1ps
module standby_halt_stop_control_tb_top;
    import shc_pkg::*;
    localparam int MID = 20;
    localparam int LONG = 40;
    typedef struct {
        logic [7:0] req;
        logic [7:0] mask;
        logic gie;
        logic nmi;
        int kind;
    } shc_row_s;

    logic clk, arst_n, do_halt, do_stop, halt_exec, stop_exec, gie, nmi, sel1, sel2;
    logic [7:0] req, mask, wdata, rdata;
    logic [3:0] addr;
    logic we, re, cpu_clk_en, osc_en, port_hold, rst_hold, wake_vec, wake_nmi, wake_next;
    shc_periph_en_s periph;
    int failures, checked, n;
    shc_row_s rows [4];
    int st [3];
    logic [2:0] codes [3];

    shc_cpu_model cpu (.clk_i(clk), .arst_n_i(arst_n), .do_halt_i(do_halt),
        .do_stop_i(do_stop), .cpu_clk_en_i(cpu_clk_en), .cpu_rst_hold_i(rst_hold),
        .halt_exec_o(halt_exec), .stop_exec_o(stop_exec));

    shc_standby_ctrl #(.SETTLE_MID_CYC(MID), .SETTLE_LONG_CYC(LONG)) DUT (
        .CLK_I(clk), .ARST_N_I(arst_n), .HALT_EXEC_I(halt_exec), .STOP_EXEC_I(stop_exec),
        .REQ_FLAGS_I(req), .MASK_BIT_I(mask), .GLOBAL_INTERRUPT_ENABLE_FLAG_I(gie),
        .NMI_REQ_I(nmi), .FIRST_COUNTER_EXT_INPUT_SEL_I(sel1),
        .SECOND_COUNTER_EXT_INPUT_SEL_I(sel2), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdata), .CPU_CLK_EN_O(cpu_clk_en),
        .OSC_EN_O(osc_en), .PERIPH_EN_O(periph), .PORT_HOLD_O(port_hold),
        .CPU_RST_HOLD_O(rst_hold), .WAKE_VECTOR_O(wake_vec), .WAKE_NMI_O(wake_nmi),
        .WAKE_NEXT_O(wake_next));

    always #12.5 clk = ~clk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : chk

    task automatic tick(input int lim);
        @(posedge clk);
        #1;
        n++;
        if (n > lim) begin
            chk(1'b0, "wait bound ran out");
            test_done();
        end
    endtask : tick

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        chk(rdata === exp, msg);
    endtask : reg_rd

    task automatic exec(input logic stop);
        @(posedge clk);
        do_stop <= stop;
        do_halt <= ~stop;
        @(posedge clk);
        do_stop <= 1'b0;
        do_halt <= 1'b0;
    endtask : exec

    task automatic set_irq(input logic [7:0] r, input logic [7:0] m, input logic g,
                           input logic x);
        @(posedge clk);
        req <= r;
        mask <= m;
        gie <= g;
        nmi <= x;
    endtask : set_irq

    task automatic wait_wake(input int lim);
        n = 0;
        while (wake_vec !== 1'b1 && wake_next !== 1'b1) tick(lim);
    endtask : wait_wake

    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk(rst_hold === 1'b1 && osc_en === 1'b1 && cpu_clk_en === 1'b0, "reset outputs");
        @(posedge clk);
        arst_n <= 1'b1;
        n = 0;
        while (rst_hold !== 1'b0) tick(100);
        chk(n >= MID - 1 && n <= MID + 3, "reset settle length");
        $display("reset test done");
    endtask : do_reset

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        {do_halt, do_stop, gie, nmi, sel1, sel2, we, re} = 8'h00;
        {req, wdata, addr} = 20'h00000;
        mask = 8'hFF;
        failures = 0;
        checked = 0;
        rows[0] = '{8'h01, 8'h01, 1'b1, 1'b0, 0};
        rows[1] = '{8'h01, 8'h00, 1'b0, 1'b0, 1};
        rows[2] = '{8'h80, 8'h7F, 1'b1, 1'b0, 2};
        rows[3] = '{8'h00, 8'hFF, 1'b0, 1'b1, 3};
        st = '{int'(SHC_SETTLE_SHORT_CYC), MID, LONG};
        codes = '{SHC_SEL_SHORT, SHC_SEL_MID, SHC_SEL_LONG};
        do_reset();
        reg_rd(SHC_REG_SETTLE, 8'h04, "settle reset value");
        reg_rd(SHC_REG_STATUS, 8'h00, "status after reset");
        reg_rd(4'h7, 8'h00, "unmapped read");
        reg_wr(SHC_REG_SETTLE, 8'h03);
        reg_rd(SHC_REG_SETTLE, 8'h04, "prohibited code kept");
        reg_wr(SHC_REG_STATUS, 8'hFF);
        reg_rd(SHC_REG_STATUS, 8'h00, "status read only");
        $display("register test done");
        foreach (rows[i]) begin
            exec(1'b0);
            repeat (3) @(posedge clk);
            #1;
            chk(cpu_clk_en === 1'b0 && osc_en === 1'b1, "halt clocks");
            chk(periph === 9'h1FB, "halt peripherals");
            chk(port_hold === 1'b1, "halt port hold");
            set_irq(rows[i].req, rows[i].mask, rows[i].gie, rows[i].nmi);
            if (rows[i].kind == 0) begin
                repeat (12) @(posedge clk);
                #1;
                chk(cpu_clk_en === 1'b0 && wake_vec === 1'b0, "masked request woke");
                reg_rd(SHC_REG_STATUS, 8'h01, "status halted");
                set_irq(8'h00, 8'hFF, 1'b0, 1'b1);
                wait_wake(20);
                chk(wake_vec === 1'b1 && wake_nmi === 1'b1 && n == 9, "nmi wake");
            end else begin
                wait_wake(20);
                if (rows[i].kind == 1) begin
                    chk(wake_next === 1'b1 && n >= 1 && n <= 2, "next wake");
                end else begin
                    chk(wake_vec === 1'b1 && n >= 9 && n <= 10, "vector wake");
                    chk(wake_nmi === (rows[i].kind == 3), "nmi cause");
                end
            end
            set_irq(8'h00, 8'hFF, 1'b0, 1'b0);
            repeat (2) @(posedge clk);
            $display("halt row %0d done", i);
        end
        set_irq(8'h04, 8'h00, 1'b0, 1'b0);
        exec(1'b0);
        wait_wake(8);
        chk(wake_next === 1'b1 && n == 1, "pending at halt entry");
        set_irq(8'h04, 8'h00, 1'b1, 1'b0);
        exec(1'b1);
        wait_wake(12);
        chk(wake_vec === 1'b1 && n == 9 && osc_en === 1'b1, "pending at stop entry");
        set_irq(8'h00, 8'hFF, 1'b0, 1'b0);
        $display("pending entry test done");
        for (int i = 0; i < 3; i++) begin
            reg_wr(SHC_REG_SETTLE, {5'h00, codes[i]});
            sel1 <= (i == 1);
            sel2 <= (i != 0);
            exec(1'b1);
            n = 0;
            while (osc_en !== 1'b0) tick(5000);
            chk(n >= st[i] && n <= st[i] + 5, "stop settle length");
            chk(cpu_clk_en === 1'b0 && port_hold === 1'b1, "stopped core");
            chk(periph === {1'b0, sel1, sel2, 5'h00, 1'b1}, "stop peripherals");
            set_irq(8'h10, 8'h10, 1'b1, 1'b1);
            repeat (MID) @(posedge clk);
            #1;
            chk(osc_en === 1'b0, "stop left by nmi or mask");
            set_irq(8'h10, 8'h00, (i == 1), 1'b0);
            wait_wake(st[i] + 20);
            if (i == 1) begin
                chk(wake_vec === 1'b1 && n >= st[i] + 9 && n <= st[i] + 14, "stop vec");
            end else begin
                chk(wake_next === 1'b1 && n >= st[i] + 1 && n <= st[i] + 6, "stop next");
            end
            set_irq(8'h00, 8'hFF, 1'b0, 1'b0);
            repeat (2) @(posedge clk);
            $display("stop code %0d done", codes[i]);
        end
        exec(1'b0);
        repeat (3) @(posedge clk);
        do_reset();
        reg_rd(SHC_REG_STATUS, 8'h00, "run after halt reset");
        reg_wr(SHC_REG_SETTLE, {5'h00, SHC_SEL_SHORT});
        exec(1'b1);
        repeat (4200) @(posedge clk);
        #1;
        chk(osc_en === 1'b0, "stop before reset");
        do_reset();
        reg_rd(SHC_REG_SETTLE, 8'h04, "settle after reset");
        test_done();
    end
endmodule : standby_halt_stop_control_tb_top
